// file: eapc_irq_ctrl.sv
// Flag, enable and mask logic for three external lines and four pin-change groups
`include "eapc_params.svh"
`default_nettype none
module eapc_irq_ctrl import eapc_pkg::*; #(
  parameter int EXT_LINES = 3,
  parameter int PC_GROUPS = 4
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire eapc_bus_type bus_req,
  output logic [7:0] bus_rdata,
  input wire logic global_irq_en,
  input wire logic [EXT_LINES-1:0] ext_line,
  input wire logic [8*PC_GROUPS-1:0] pin_change_input,
  input wire eapc_ack_type vec_ack,
  output logic [EXT_LINES+PC_GROUPS-1:0] irq_req
);

  localparam int PC_PINS = 8 * PC_GROUPS;
  localparam logic [3:0][7:0] MASK_OFS = {`EAPC_OFS_MASK3, `EAPC_OFS_MASK2,
                                          `EAPC_OFS_MASK1, `EAPC_OFS_MASK0};

  // Sample state
  logic [EXT_LINES-1:0] ext_smp_r, ext_smp_nxt, ext_prev_r, ext_prev_nxt;
  logic [PC_PINS-1:0] pc_smp_r, pc_smp_nxt, pc_prev_r, pc_prev_nxt;
  logic primed_r, primed_nxt;

  // Register state
  logic [EXT_LINES-1:0] ext_flag_r, ext_flag_nxt, ext_en_r, ext_en_nxt;
  logic [2*EXT_LINES-1:0] sense_r, sense_nxt;
  logic [PC_GROUPS-1:0] pc_flag_r, pc_flag_nxt, pc_en_r, pc_en_nxt;
  logic [PC_PINS-1:0] pc_mask_r, pc_mask_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  // Decode results and events
  logic [7:0] eff_addr;
  logic data_space;
  logic wr_pc_flag, wr_ext_flag, wr_ext_en, wr_pc_en, wr_sense;
  logic [PC_GROUPS-1:0] wr_mask;
  logic [EXT_LINES-1:0] ext_set, ext_clr, ext_level;
  logic [PC_GROUPS-1:0] pc_set, pc_clr;

  // I/O-space accesses reach the low 64 locations, shifted up by the I/O base
  assign eff_addr = bus_req.io_space ? (8'(bus_req.addr[5:0]) + `EAPC_IO_BASE) : bus_req.addr;
  assign data_space = !bus_req.io_space;

  // Write strobes; extended space only answers data-space stores
  assign wr_pc_flag = bus_req.wr && eff_addr == `EAPC_OFS_PC_FLAG;
  assign wr_ext_flag = bus_req.wr && eff_addr == `EAPC_OFS_EXT_FLAG;
  assign wr_ext_en = bus_req.wr && eff_addr == `EAPC_OFS_EXT_EN;
  assign wr_pc_en = bus_req.wr && data_space && eff_addr == `EAPC_OFS_PC_EN;
  assign wr_sense = bus_req.wr && data_space && eff_addr == `EAPC_OFS_SENSE;

  // Sample pins once, keep the previous sample for edge and change detection
  always_comb begin
    ext_smp_nxt = ext_line;
    ext_prev_nxt = ext_smp_r;
    pc_smp_nxt = pin_change_input;
    pc_prev_nxt = pc_smp_r;
    primed_nxt = 1'b1;
  end

  // After reset the previous sample is stale, so events wait one cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_smp_r <= '0;
      ext_prev_r <= '0;
      pc_smp_r <= '0;
      pc_prev_r <= '0;
      primed_r <= 1'b0;
    end else begin
      ext_smp_r <= ext_smp_nxt;
      ext_prev_r <= ext_prev_nxt;
      pc_smp_r <= pc_smp_nxt;
      pc_prev_r <= pc_prev_nxt;
      primed_r <= primed_nxt;
    end
  end

  // Per external line: trigger select, flag and request
  genvar gi;
  generate
    for (gi = 0; gi < EXT_LINES; gi++) begin : g_ext
      logic [1:0] sel;
      logic rise, fall, evt;
      assign sel = sense_r[2*gi +: 2];
      assign rise = ext_smp_r[gi] && !ext_prev_r[gi];
      assign fall = !ext_smp_r[gi] && ext_prev_r[gi];
      assign ext_level[gi] = sel == `EAPC_SENSE_LOW;
      always_comb begin
        unique case (sel)
          `EAPC_SENSE_LOW: evt = 1'b0;
          `EAPC_SENSE_ANY: evt = rise || fall;
          `EAPC_SENSE_FALL: evt = fall;
          `EAPC_SENSE_RISE: evt = rise;
        endcase
      end
      assign ext_set[gi] = primed_r && evt;
      assign ext_clr[gi] = (wr_ext_flag && bus_req.wdata[gi])
                           || (vec_ack.valid && vec_ack.index == 3'(gi));
      // Level mode asks from the registered pin sample, the flag plays no part
      assign irq_req[gi] = ext_en_r[gi] && global_irq_en
                           && (ext_level[gi] ? !ext_smp_r[gi] : ext_flag_r[gi]);
    end
  endgenerate

  // Per pin-change group: masked change detect, flag and request
  generate
    for (gi = 0; gi < PC_GROUPS; gi++) begin : g_pc
      logic [7:0] chg;
      assign wr_mask[gi] = bus_req.wr && data_space && eff_addr == MASK_OFS[gi];
      assign chg = (pc_smp_r[8*gi +: 8] ^ pc_prev_r[8*gi +: 8])
                   & pc_mask_r[8*gi +: 8] & {8{pc_en_r[gi]}};
      assign pc_set[gi] = primed_r && |chg;
      assign pc_clr[gi] = (wr_pc_flag && bus_req.wdata[gi])
                          || (vec_ack.valid && vec_ack.index == 3'(EXT_LINES + gi));
      assign irq_req[EXT_LINES+gi] = pc_flag_r[gi] && pc_en_r[gi] && global_irq_en;
    end
  endgenerate

  // Next register values; a set in the clearing cycle wins over the clear
  always_comb begin
    ext_flag_nxt = ((ext_flag_r & ~ext_clr) | ext_set) & ~ext_level;
    pc_flag_nxt = (pc_flag_r & ~pc_clr) | pc_set;
    ext_en_nxt = wr_ext_en ? bus_req.wdata[EXT_LINES-1:0] : ext_en_r;
    sense_nxt = wr_sense ? bus_req.wdata[2*EXT_LINES-1:0] : sense_r;
    pc_en_nxt = wr_pc_en ? bus_req.wdata[PC_GROUPS-1:0] : pc_en_r;
    pc_mask_nxt = pc_mask_r;
    for (int g = 0; g < PC_GROUPS; g++) begin
      if (wr_mask[g]) begin
        pc_mask_nxt[8*g +: 8] = bus_req.wdata;
      end
    end
  end

  // Read data, registered; unmapped locations read zero
  always_comb begin
    rdata_nxt = rdata_r;
    if (bus_req.rd) begin
      rdata_nxt = `EAPC_RST_REG;
      if (eff_addr == `EAPC_OFS_PC_FLAG) begin
        rdata_nxt = 8'(pc_flag_r) & `EAPC_PC_BITS;
      end else if (eff_addr == `EAPC_OFS_EXT_FLAG) begin
        rdata_nxt = 8'(ext_flag_r) & `EAPC_EXT_BITS;
      end else if (eff_addr == `EAPC_OFS_EXT_EN) begin
        rdata_nxt = 8'(ext_en_r) & `EAPC_EXT_BITS;
      end else if (data_space && eff_addr == `EAPC_OFS_PC_EN) begin
        rdata_nxt = 8'(pc_en_r) & `EAPC_PC_BITS;
      end else if (data_space && eff_addr == `EAPC_OFS_SENSE) begin
        rdata_nxt = 8'(sense_r) & `EAPC_SENSE_BITS;
      end else begin
        for (int g = 0; g < PC_GROUPS; g++) begin
          if (data_space && eff_addr == MASK_OFS[g]) begin
            rdata_nxt = pc_mask_r[8*g +: 8];
          end
        end
      end
    end
  end

  // Register bank; everything software sees clears on reset
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ext_flag_r <= '0;
      ext_en_r <= '0;
      sense_r <= '0;
      pc_flag_r <= '0;
      pc_en_r <= '0;
      pc_mask_r <= '0;
      rdata_r <= `EAPC_RST_REG;
    end else begin
      ext_flag_r <= ext_flag_nxt;
      ext_en_r <= ext_en_nxt;
      sense_r <= sense_nxt;
      pc_flag_r <= pc_flag_nxt;
      pc_en_r <= pc_en_nxt;
      pc_mask_r <= pc_mask_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign bus_rdata = rdata_r;

  // Checks, written for line 0 and group 0
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  ext_flag_set_a: assert property (ext_set[0] && !ext_level[0] |=> ext_flag_r[0])
    else $error("external line flag not set by its event");

  ext_req_gate_a: assert property (!ext_level[0] |->
      irq_req[0] == (ext_flag_r[0] && ext_en_r[0] && global_irq_en))
    else $error("external request not gated by flag and enables");

  ack_clear_a: assert property (vec_ack.valid && vec_ack.index == 3'(EXT_LINES)
      && !pc_set[0] |=> !pc_flag_r[0])
    else $error("taken pin-change vector left flag set");

  one_clears_a: assert property (wr_pc_flag && bus_req.wdata[0] && !pc_set[0] |=> !pc_flag_r[0])
    else $error("writing one did not clear group flag");

  zero_keeps_a: assert property (wr_pc_flag && !bus_req.wdata[0] && pc_flag_r[0]
      && !(vec_ack.valid && vec_ack.index == 3'(EXT_LINES)) |=> pc_flag_r[0])
    else $error("writing zero changed group flag");

  level_flag_a: assert property (ext_level[0] && $past(ext_level[0]) |-> !ext_flag_r[0])
    else $error("flag set while line in low-level mode");

  level_req_a: assert property (ext_level[0] |->
      irq_req[0] == (!ext_smp_r[0] && ext_en_r[0] && global_irq_en))
    else $error("level request does not follow the pin");

  pc_req_gate_a: assert property (irq_req[EXT_LINES] ==
      (pc_flag_r[0] && pc_en_r[0] && global_irq_en))
    else $error("group request not gated by flag and enables");

  masked_quiet_a: assert property (pc_mask_r[7:0] == 8'h00 && !pc_flag_r[0]
      && !wr_mask[0] ##1 pc_mask_r[7:0] == 8'h00 |-> !pc_flag_r[0])
    else $error("masked inputs raised group flag");

  pc_change_a: assert property (primed_r && pc_en_r[0] && |((pc_smp_r[7:0] ^ pc_prev_r[7:0])
      & pc_mask_r[7:0]) |=> pc_flag_r[0])
    else $error("enabled pin change did not set group flag");

  io_alias_a: assert property (bus_req.rd && bus_req.io_space
      && bus_req.addr[5:0] == 6'h1b ##1 1'b1 |-> bus_rdata == 8'($past(pc_flag_r)))
    else $error("I/O-space read of group flags wrong");

  io_no_ext_a: assert property (bus_req.wr && bus_req.io_space |=> $stable(pc_mask_r) && $stable(pc_en_r))
    else $error("I/O-space write reached extended register");

  // Per-line checks; the ones above only watch line 0
  generate
    for (gi = 0; gi < EXT_LINES; gi++) begin : g_ext_chk
      // Each of the three edge sense codes must catch its own edge, whatever the pin direction
      ext_rise_a: assert property (sense_r[2*gi +: 2] == `EAPC_SENSE_RISE
          && primed_r && ext_smp_r[gi] && !ext_prev_r[gi]
          |=> ext_flag_r[gi])
        else $error("rising edge missed on external line");

      ext_fall_a: assert property (sense_r[2*gi +: 2] == `EAPC_SENSE_FALL
          && primed_r && !ext_smp_r[gi] && ext_prev_r[gi]
          |=> ext_flag_r[gi])
        else $error("falling edge missed on external line");

      ext_any_a: assert property (sense_r[2*gi +: 2] == `EAPC_SENSE_ANY
          && primed_r && ext_smp_r[gi] != ext_prev_r[gi]
          |=> ext_flag_r[gi])
        else $error("change missed on external line");

      // The wrong edge must leave a clear flag alone
      ext_wrong_edge_a: assert property (sense_r[2*gi +: 2] == `EAPC_SENSE_RISE
          && !ext_flag_r[gi] && !(ext_smp_r[gi] && !ext_prev_r[gi])
          |=> !ext_flag_r[gi])
        else $error("external flag set without a rising edge");

      ext_level_zero_a: assert property (ext_level[gi] && $past(ext_level[gi])
          |-> !ext_flag_r[gi])
        else $error("external flag held in level mode");

      ext_req_en_a: assert property (irq_req[gi] |-> ext_en_r[gi] && global_irq_en)
        else $error("external request without its enables");

      ext_w1c_a: assert property (wr_ext_flag && bus_req.wdata[gi] && !ext_set[gi]
          |=> !ext_flag_r[gi])
        else $error("writing one left external flag set");
    end
  endgenerate

  // Per-group checks; the ones above only watch group 0
  generate
    for (gi = 0; gi < PC_GROUPS; gi++) begin : g_pc_chk
      pc_set_a: assert property (pc_set[gi] |=> pc_flag_r[gi])
        else $error("group event did not set its flag");

      // A disabled group stays silent whatever its pins do
      pc_off_quiet_a: assert property (!pc_en_r[gi] && !pc_flag_r[gi]
          |=> !pc_flag_r[gi])
        else $error("disabled group raised its flag");

      pc_ack_a: assert property (vec_ack.valid && vec_ack.index == 3'(EXT_LINES + gi)
          && !pc_set[gi] |=> !pc_flag_r[gi])
        else $error("taken group vector left its flag set");

      pc_mask_wr_a: assert property (wr_mask[gi]
          |=> pc_mask_r[8*gi +: 8] == $past(bus_req.wdata))
        else $error("mask write did not land");
    end
  endgenerate

  // Reset must leave every software-visible bit at zero
  reset_clear_a: assert property (@(posedge clk) disable iff (1'b0) $past(sys_rst)
      |-> ext_flag_r == '0 && pc_flag_r == '0 && pc_en_r == '0
      && pc_mask_r == '0 && ext_en_r == '0 && sense_r == '0)
    else $error("state not cleared by reset");

  // The stale sample right after reset must not fake an event
  prime_quiet_a: assert property (!primed_r |-> ext_set == '0 && pc_set == '0)
    else $error("event raised before first fresh sample");

endmodule : eapc_irq_ctrl
`default_nettype wire

// file: eapc_params.svh
// Register offsets, field codes and reset values for the external and pin-change interrupt block
`ifndef EAPC_PARAMS_SVH
`define EAPC_PARAMS_SVH

`define EAPC_OFS_PC_FLAG 8'h3b
`define EAPC_OFS_EXT_FLAG 8'h3c
`define EAPC_OFS_EXT_EN 8'h3d
`define EAPC_OFS_PC_EN 8'h68
`define EAPC_OFS_SENSE 8'h69
`define EAPC_OFS_MASK0 8'h6b
`define EAPC_OFS_MASK1 8'h6c
`define EAPC_OFS_MASK2 8'h6d
`define EAPC_OFS_MASK3 8'h73
`define EAPC_IO_BASE 8'h20
`define EAPC_EXT_SPACE 8'h60

`define EAPC_SENSE_LOW 2'h0
`define EAPC_SENSE_ANY 2'h1
`define EAPC_SENSE_FALL 2'h2
`define EAPC_SENSE_RISE 2'h3

`define EAPC_RST_REG 8'h00
`define EAPC_SENSE_BITS 8'h3f
`define EAPC_EXT_BITS 8'h07
`define EAPC_PC_BITS 8'h0f

`endif

// file: eapc_pkg.sv
// Types shared by the external and pin-change interrupt block
`default_nettype none
package eapc_pkg;

  // One register access from the core, data space or I/O space
  typedef struct packed {
    logic io_space;
    logic rd;
    logic wr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } eapc_bus_type;

  // Vector taken by the core: 0..2 external lines, 3..6 pin-change groups
  typedef struct packed {
    logic valid;
    logic [2:0] index;
  } eapc_ack_type;

endpackage : eapc_pkg
`default_nettype wire

// file: eapc_core_model.sv
// Behavioural core that takes requested vectors, promptly or after a lag
`default_nettype none
module eapc_core_model import eapc_pkg::*; (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ack_en,
  input wire logic [3:0] lag,
  input wire logic [6:0] irq_req,
  output eapc_ack_type vec_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  int i;
  // Take the lowest pending vector; idle index flips so a stale one never looks valid
  initial begin
    vec_ack = '{1'b0, 3'h5};
    forever begin
      @(posedge clk);
      #1;
      if (!sys_rst && ack_en && irq_req != 7'h00) begin
        repeat (lag) begin
          @(posedge clk);
          #1;
        end
        for (i = 6; i >= 0; i--) if (irq_req[i]) vec_ack = '{1'b1, 3'(i)};
        @(posedge clk);
        #1;
        vec_ack = '{1'b0, ~vec_ack.index}; // One pulse per taken vector
      end
    end
  end
endmodule : eapc_core_model
`default_nettype wire

// file: ext_and_pin_change_irq_bench.sv
// Self-checking bench for the external and pin-change interrupt block
`include "eapc_params.svh"
`default_nettype none
module ext_and_pin_change_irq_bench import eapc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, sys_rst, global_irq_en, ack_en;
  eapc_bus_type bus_req;
  eapc_ack_type vec_ack;
  logic [7:0] bus_rdata, exp;
  logic [2:0] ext_line;
  logic [31:0] pins, seed;
  logic [6:0] irq_req;
  logic [3:0] lag;
  int fails, n_checks, g, b, l, m;
  logic [7:0] regs [10] = '{8'h3b, 8'h3c, 8'h3d, 8'h68, 8'h69, 8'h6b, 8'h6c, 8'h6d, 8'h73, 8'h50};
  logic [7:0] mo [4] = '{`EAPC_OFS_MASK0, `EAPC_OFS_MASK1, `EAPC_OFS_MASK2, `EAPC_OFS_MASK3};

  eapc_irq_ctrl u_dut (.clk(clk), .sys_rst(sys_rst), .bus_req(bus_req), .bus_rdata(bus_rdata),
    .global_irq_en(global_irq_en), .ext_line(ext_line), .pin_change_input(pins), .vec_ack(vec_ack),
    .irq_req(irq_req));
  eapc_core_model u_core (.clk(clk), .sys_rst(sys_rst), .ack_en(ack_en), .lag(lag), .irq_req(irq_req),
    .vec_ack(vec_ack));

  // Free-running 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : xs

  task automatic check(input logic [7:0] got, input logic [7:0] want);
    n_checks++;
    if (got !== want) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, want);
    end
  endtask : check

  task automatic final_report();
    $display("checks=%0d mismatches=%0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : final_report

  task automatic step(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : step

  // One access, then an idle cycle so the strobe never rises twice in one step
  task automatic acc(input logic io, input logic rd, input logic [7:0] a, input logic [7:0] d,
                     input logic [7:0] want);
    bus_req = '{io, rd, ~rd, a, d};
    step(1);
    if (rd) check(bus_rdata, want);
    bus_req = '0;
    step(1);
  endtask : acc

  // Bounded wait for one request line; running out ends the run
  task automatic wait_irq(input int i, input logic v);
    int k;
    for (k = 0; k < 20 && irq_req[i] !== v; k++) step(1);
    check({7'h0, irq_req[i]}, {7'h0, v});
    if (irq_req[i] !== v) final_report();
  endtask : wait_irq

  // Main sequence: reset values, pin-change groups, external lines
  initial begin
    seed = 32'd87253;
    fails = 0;
    n_checks = 0;
    sys_rst = 1'b1;
    bus_req = '0;
    global_irq_en = 1'b0;
    ext_line = 3'h7;
    pins = 32'h0;
    ack_en = 1'b0;
    lag = 4'h0;
    step(12);
    sys_rst = 1'b0;
    for (g = 0; g < 10; g++) acc(1'b0, 1'b1, regs[g], 8'h00, 8'h00);
    check({1'b0, irq_req}, 8'h00);
    acc(1'b1, 1'b0, `EAPC_OFS_PC_EN, 8'h0f, 8'h00);
    acc(1'b0, 1'b1, `EAPC_OFS_PC_EN, 8'h00, 8'h00);
    acc(1'b0, 1'b0, `EAPC_OFS_PC_EN, 8'h0f, 8'h00);
    global_irq_en = 1'b1;
    for (g = 0; g < 4; g++) begin
      b = int'(xs() % 8);
      acc(1'b0, 1'b0, mo[g], 8'h01 << b, 8'h00);
      acc(1'b0, 1'b1, mo[g], 8'h00, 8'h01 << b);
      pins = pins ^ ((xs() & ~(32'h1 << b) & 32'hff) << (8 * g));
      step(4);
      acc(1'b1, 1'b1, 8'h1b, 8'h00, 8'h00);
      pins[8 * g + b] = ~pins[8 * g + b];
      wait_irq(3 + g, 1'b1);
      acc(1'b1, 1'b1, 8'h1b, 8'h00, 8'h01 << g);
      global_irq_en = 1'b0;
      step(1);
      check({7'h0, irq_req[3 + g]}, 8'h00);
      global_irq_en = 1'b1;
      acc(1'b0, 1'b0, `EAPC_OFS_PC_FLAG, ~(8'h01 << g), 8'h00);
      acc(1'b0, 1'b1, `EAPC_OFS_PC_FLAG, 8'h00, 8'h01 << g);
      ack_en = 1'b1;
      lag = 4'(g);
      wait_irq(3 + g, 1'b0);
      ack_en = 1'b0;
      acc(1'b0, 1'b1, `EAPC_OFS_PC_FLAG, 8'h00, 8'h00);
    end
    acc(1'b0, 1'b0, `EAPC_OFS_EXT_EN, 8'h07, 8'h00);
    for (l = 0; l < 3; l++) begin
      for (m = 1; m < 4; m++) begin
        acc(1'b0, 1'b0, `EAPC_OFS_SENSE, 8'(m << (2 * l)), 8'h00);
        acc(1'b0, 1'b0, `EAPC_OFS_EXT_FLAG, 8'h07, 8'h00);
        for (b = 0; b < 2; b++) begin
          ext_line[l] = ~ext_line[l];
          step(3);
          exp = (m == 1 || (m == 3) == ext_line[l]) ? 8'(1 << l) : 8'h00;
          acc(1'b1, 1'b1, 8'h1c, 8'h00, exp);
          check({7'h0, irq_req[l]}, exp >> l);
          acc(1'b1, 1'b0, 8'h1c, exp, 8'h00);
          acc(1'b0, 1'b1, `EAPC_OFS_EXT_FLAG, 8'h00, 8'h00);
        end
      end
    end
    acc(1'b0, 1'b0, `EAPC_OFS_SENSE, 8'h00, 8'h00);
    ext_line[0] = 1'b0;
    wait_irq(0, 1'b1);
    acc(1'b0, 1'b1, `EAPC_OFS_EXT_FLAG, 8'h00, 8'h00);
    ext_line[0] = 1'b1;
    wait_irq(0, 1'b0);
    final_report();
  end
endmodule : ext_and_pin_change_irq_bench
`default_nettype wire
